//--- common/cec_map.vh
// Purpose: register map and field layout of the capture edge control block
// Assumes: one 32-bit aligned APB word per register, data in bits 7:0
// Notes: printed offsets are register indices; byte address is index * 4
`ifndef CEC_MAP_VH
`define CEC_MAP_VH

// register indices as printed
`define CEC_IDX_PINS_1_2 16'h104A
`define CEC_IDX_PINS_3_4 16'h104B
`define CEC_IDX_PINS_5_6 16'h104C

// byte addresses on the APB side (index * 4)
`define CEC_ADDR_PINS_1_2 16'h4128
`define CEC_ADDR_PINS_3_4 16'h412C
`define CEC_ADDR_PINS_5_6 16'h4130

// field positions inside one pin's nibble
`define CEC_FLD_FALL 0
`define CEC_FLD_RISE 1
`define CEC_FLD_FLAG 2
`define CEC_FLD_ENA 3

// the upper pin of a register uses the nibble starting here
`define CEC_UPPER_BASE 4

// every control bit clears to this at reset
`define CEC_CTL_RESET 8'h00

// answer to an unmapped read
`define CEC_RDATA_NONE 32'h0000_0000

`endif

//--- dv/cec_capture_ctrl_asserts.sv
// Purpose: port checks for the capture edge control block
// Assumes: zero wait state slave, trigger three samples after new pin level
// Notes: trigger cause check waits out the first cycles after reset
`timescale 1ns/100ps
`include "cec_map.vh"
module cec_chk #(
    parameter PINS = 6,
    parameter ADDR_W = 16
) (
    input wire clock,
    input wire rst_b,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire capture_input_1,
    input wire capture_input_2,
    input wire capture_input_3,
    input wire capture_input_4,
    input wire capture_input_5,
    input wire capture_input_6,
    input wire [PINS-1:0] capture_trigger,
    input wire [PINS-1:0] irq_request,
    input wire irq_any
);
    wire [5:0] pins = {capture_input_6, capture_input_5, capture_input_4,
        capture_input_3, capture_input_2, capture_input_1};
    wire acc = psel && penable;
    wire hit = paddr == `CEC_ADDR_PINS_1_2 || paddr == `CEC_ADDR_PINS_3_4 ||
        paddr == `CEC_ADDR_PINS_5_6;
    logic [2:0] age_q;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    // pins held at reset may give one event; skip that stretch
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) age_q <= 3'h0;
        else if (age_q != 3'h7) age_q <= age_q + 3'h1;
    end
    property p_any; irq_any == |irq_request; endproperty
    a_any: assert property (p_any) else $error("summary mismatch");
    property p_trg; age_q == 3'h7 |->
        (capture_trigger & ~($past(pins, 3) ^ $past(pins, 4))) == 6'h0;
    endproperty
    a_trg: assert property (p_trg) else $error("trigger no edge");
    property p_err; acc && !hit |-> pslverr && prdata == 32'h0; endproperty
    a_err: assert property (p_err) else $error("unmapped ok");
    property p_ok; acc && hit |-> !pslverr; endproperty
    a_ok: assert property (p_ok) else $error("mapped error");
    property p_hi; acc && !pwrite |-> prdata[31:8] == 24'h0; endproperty
    a_hi: assert property (p_hi) else $error("upper bits set");
    property p_clr; acc && pwrite && pstrb[0] && pwdata[7:0] == 8'h00 &&
        paddr == `CEC_ADDR_PINS_1_2 |-> ##2 irq_request[1:0] == 2'b00;
    endproperty
    a_clr: assert property (p_clr) else $error("request kept");
    property p_fall; |($past(irq_request) & ~irq_request) |->
        $past(acc && pwrite, 1) || $past(acc && pwrite, 2);
    endproperty
    a_fall: assert property (p_fall) else $error("flag lost");
    property p_rst; $rose(rst_b) |-> capture_trigger == 6'h0 &&
        irq_request == 6'h0; endproperty
    a_rst: assert property (p_rst) else $error("reset outputs");
endmodule // cec_chk
bind cec_capture_ctrl cec_chk #(.PINS(PINS), .ADDR_W(ADDR_W)) u_chk (
    .clock, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .capture_input_1, .capture_input_2,
    .capture_input_3, .capture_input_4, .capture_input_5, .capture_input_6,
    .capture_trigger, .irq_request, .irq_any);

//--- dv/cec_pin_src.sv
// Purpose: outside sources for the six capture pins
// Assumes: bench asks for a pin level on a rising edge
// Notes: levels change once per cycle, so no pulse is shorter than a clock
`timescale 1ns/100ps
module cec_pin_src (
    input wire clock,
    input wire [5:0] want,
    output logic [5:0] pin
);
    // lag one cycle behind the request, like a source off the chip
    always @(posedge clock) begin
        pin <= want;
    end
endmodule // cec_pin_src

//--- dv/tb_capture_edge_interrupt_ctrl.sv
// Purpose: every edge mode on every pin, flags, enables and map
// Assumes: expected reads and triggers are queued before they appear
// Notes: pwdata upper bits are random and must be ignored
`timescale 1ns/100ps
`include "cec_map.vh"
module tb_capture_edge_interrupt_ctrl;
    logic clock = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
    logic [15:0] paddr = 16'h0;
    logic [31:0] pwdata = 32'h0, prdata, seed = 32'h8158_d5df;
    logic [3:0] pstrb = 4'h0;
    logic [5:0] want = 6'h0, pin, trg, irq;
    logic pready, pslverr, irq_any;
    logic [33:0] q_rd[$];
    logic [5:0] q_tg[$];
    int error_cnt = 0, compares = 0;
    always #5 clock = ~clock;
    cec_pin_src i_src (.clock, .want, .pin);
    cec_capture_ctrl i_dut (.clock, .rst_b, .psel, .penable, .pwrite,
        .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
        .capture_input_1(pin[0]), .capture_input_2(pin[1]),
        .capture_input_3(pin[2]), .capture_input_4(pin[3]),
        .capture_input_5(pin[4]), .capture_input_6(pin[5]),
        .capture_trigger(trg), .irq_request(irq), .irq_any);
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task finish_test();
        if (error_cnt == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task cmp_rd(input logic [33:0] e, input logic [33:0] g);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] read exp %h got %h", e, g);
        end
    endtask
    task cmp_tg(input logic [5:0] e, input logic [5:0] g);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] trigger exp %h got %h", e, g);
        end
    endtask
    task cmp_irq(input logic [5:0] e, input logic [5:0] g);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] irq_request exp %h got %h", e, g);
        end
    endtask
    // one transfer; the read note goes in before the access edge
    task apb(input logic w, input logic [15:0] a, input logic [7:0] d,
        input logic [33:0] e);
        logic [31:0] r;
        int n;
        r = xs();
        n = 0;
        @(posedge clock);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, r[31:8], d};
        pstrb <= {3'h0, w}; // strobes stay low on reads
        if (!w) q_rd.push_back(e);
        @(posedge clock) penable <= 1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            error_cnt++;
            finish_test();
        end
        psel <= 0;
        penable <= 0;
    endtask
    // watcher: each result takes the oldest note
    always @(posedge clock) begin
        if (psel && penable && pready && !pwrite)
            cmp_rd(q_rd.size() ? q_rd.pop_front() : 34'bx,
                {irq_any, pslverr, prdata});
        if (trg !== 6'h0)
            cmp_tg(q_tg.size() ? q_tg.pop_front() : 6'bx, trg);
    end
    initial begin
        logic [15:0] a;
        logic [7:0] v;
        int sh;
        repeat (3) @(posedge clock);
        rst_b <= 1;
        for (int i = 0; i < 4; i++)
            apb(0, `CEC_ADDR_PINS_1_2 + 16'(4 * i), 8'h0,
                i == 3 ? {2'b01, 32'h0} : 34'h0);
        for (int p = 0; p < 6; p++) begin
            for (int m = 0; m < 4; m++) begin
                a = `CEC_ADDR_PINS_1_2 + 16'(4 * (p / 2));
                sh = 4 * (p % 2);
                v = {4'h0, p[0], 1'b1, m[1:0]} << sh;
                apb(1, a, v, 34'h0);
                if (m[1]) q_tg.push_back(6'h1 << p);
                @(posedge clock) want[p] <= 1;
                repeat (8) @(posedge clock);
                if (m[0]) q_tg.push_back(6'h1 << p);
                @(posedge clock) want[p] <= 0;
                repeat (8) @(posedge clock);
                v = {4'h0, p[0], m != 0, m[1:0]} << sh;
                apb(0, a, 8'h0, {p[0] && m != 0, 25'h0, v});
                cmp_irq(6'(p[0] && m != 0) << p, irq);
                apb(1, a, 8'h0, 34'h0);
                apb(0, a, 8'h0, 34'h0);
                cmp_irq(6'h0, irq);
            end
        end
        // let the watcher take the last read before counting leftovers
        repeat (2) @(posedge clock);
        cmp_rd(34'h0, 34'(q_tg.size() + q_rd.size()));
        finish_test();
    end
    initial begin
        repeat (20000) @(posedge clock);
        error_cnt++;
        $display("[FAIL] run_time exp done got hang");
        finish_test();
    end
endmodule // tb_capture_edge_interrupt_ctrl

//--- verilog/cec_capture_ctrl.v
// Purpose: edge select, pending flag and interrupt enable for six capture
//          inputs, three 8-bit control registers on an APB slave
// Assumes: capture inputs are asynchronous to clock; APB master on clock
// Notes: flags are cleared by writing 0 to them; writing 1 leaves them
//        alone, and a new edge in the clearing cycle keeps the flag set
//
// Behaviour
// RULE_01 - two select bits: none off, fall only, rise only, both edges
// RULE_02 - lower pin: bit 0 falling select, bit 1 rising select
// RULE_03 - upper pin: bit 4 falling select, bit 5 rising select
// RULE_04 - selected edge sets pin pending flag, bit 2 for lower pin
// RULE_05 - pending flag reads 1 while pending, 0 when inactive
// RULE_06 - software must clear the flag while servicing an enabled interrupt
// RULE_07 - enable bit 3 lets a selected edge request an interrupt
// RULE_08 - flags read and clear only; others read-write; all reset to 0
// RULE_09 - pins 3/4 register at index 104Bh, pins 5/6 at 104Ch
// RULE_10 - pins 1/2 register at 104Ah; upper flag bit 6, enable bit 7
// RULE_11 - inputs synchronised; edges found by comparing consecutive samples
// RULE_12 - flag sets regardless of enable; request is flag and enable
`timescale 1ns/100ps
`include "cec_map.vh"

module cec_capture_ctrl #(
    parameter PINS = 6,
    parameter ADDR_W = 16
) (
    input wire clock,
    input wire rst_b,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output wire [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire capture_input_1,
    input wire capture_input_2,
    input wire capture_input_3,
    input wire capture_input_4,
    input wire capture_input_5,
    input wire capture_input_6,
    output wire [PINS-1:0] capture_trigger,
    output wire [PINS-1:0] irq_request,
    output wire irq_any
);

    // number of control registers, two pins each
    localparam REGS = 3;

    // gather the pins into one vector, pin 1 in bit 0
    wire [PINS-1:0] pin_raw;
    assign pin_raw = {capture_input_6, capture_input_5, capture_input_4,
                      capture_input_3, capture_input_2, capture_input_1};

    // ------------------------------------------------------------------
    // apb address decode
    // ------------------------------------------------------------------

    wire [ADDR_W-1:0] addr_p12;
    wire [ADDR_W-1:0] addr_p34;
    wire [ADDR_W-1:0] addr_p56;
    wire [REGS-1:0] sel_reg;
    wire mapped;
    wire setup_phase;
    wire access_phase;
    wire [REGS-1:0] wr_reg;

    // register positions as byte addresses
    assign addr_p12 = `CEC_ADDR_PINS_1_2; // RULE_10
    assign addr_p34 = `CEC_ADDR_PINS_3_4; // RULE_09
    assign addr_p56 = `CEC_ADDR_PINS_5_6; // RULE_09

    // one select line per register
    assign sel_reg[0] = (paddr == addr_p12);
    assign sel_reg[1] = (paddr == addr_p34);
    assign sel_reg[2] = (paddr == addr_p56);
    assign mapped = |sel_reg;

    assign setup_phase = psel & ~penable;
    assign access_phase = psel & penable;

    // writes land in the access phase; byte lane 0 carries all 8 bits,
    // so a write without lane 0 changes nothing
    assign wr_reg = sel_reg & {REGS{access_phase & pwrite & pstrb[0]}};

    // zero wait states: every access finishes in its first access cycle
    assign pready = 1'b1;

    // ------------------------------------------------------------------
    // per-pin state: synchroniser, edge detect, control and flag bits
    // ------------------------------------------------------------------

    reg [PINS-1:0] sync1_q;
    reg [PINS-1:0] sync2_q;
    reg [PINS-1:0] last_q;
    reg [PINS-1:0] fall_sel_q;
    reg [PINS-1:0] rise_sel_q;
    reg [PINS-1:0] ena_q;
    reg [PINS-1:0] flag_q;
    reg [PINS-1:0] trig_q;
    reg [PINS-1:0] irq_q;
    reg irq_any_q;

    wire [PINS-1:0] rise_ev;
    wire [PINS-1:0] fall_ev;
    wire [PINS-1:0] hit;
    wire [PINS-1:0] pin_wr;
    wire [PINS-1:0] fall_sel_d;
    wire [PINS-1:0] rise_sel_d;
    wire [PINS-1:0] ena_d;
    wire [PINS-1:0] flag_d;
    wire [PINS-1:0] flag_clr;

    // read image: pin i owns nibble i, so register r is byte r
    wire [PINS*4-1:0] ctl_vec;

    genvar i;
    generate
        for (i = 0; i < PINS; i = i + 1) begin : g_pin
            // nibble base inside the register byte for this pin
            localparam integer BASE = (i % 2) * `CEC_UPPER_BASE;
            localparam integer REG = i / 2;

            // two flops take the pin into the clock domain; only the
            // second stage feeds the edge compare
            always @(posedge clock or negedge rst_b) begin
                if (!rst_b) begin
                    sync1_q[i] <= 1'b0;
                    sync2_q[i] <= 1'b0;
                    last_q[i] <= 1'b0;
                end else begin
                    sync1_q[i] <= pin_raw[i]; // RULE_11
                    sync2_q[i] <= sync1_q[i]; // RULE_11
                    last_q[i] <= sync2_q[i]; // RULE_11
                end
            end

            // one event per transition of the sampled level
            assign rise_ev[i] = sync2_q[i] & ~last_q[i]; // RULE_11
            assign fall_ev[i] = ~sync2_q[i] & last_q[i]; // RULE_11

            // edge selection: neither, one or both edges count
            assign hit[i] = (rise_ev[i] & rise_sel_q[i]) |
                            (fall_ev[i] & fall_sel_q[i]); // RULE_01

            // this pin's register is being written
            assign pin_wr[i] = wr_reg[REG];

            // select bits sit at 0/1 (lower) or 4/5 (upper)
            assign fall_sel_d[i] = pin_wr[i] ?
                pwdata[BASE + `CEC_FLD_FALL] : fall_sel_q[i]; // RULE_02
            assign rise_sel_d[i] = pin_wr[i] ?
                pwdata[BASE + `CEC_FLD_RISE] : rise_sel_q[i]; // RULE_03

            // enable bit 3 (lower) or 7 (upper), plain read-write
            assign ena_d[i] = pin_wr[i] ?
                pwdata[BASE + `CEC_FLD_ENA] : ena_q[i]; // RULE_07

            // software can only clear the flag, by writing 0 to it
            assign flag_clr[i] = pin_wr[i] &
                ~pwdata[BASE + `CEC_FLD_FLAG]; // RULE_08

            // a new edge wins over a clear in the same cycle, so no
            // event is lost while the handler tidies up
            assign flag_d[i] = hit[i] |
                (flag_q[i] & ~flag_clr[i]); // RULE_04 RULE_12

            // control and flag storage, all zero after reset
            always @(posedge clock or negedge rst_b) begin
                if (!rst_b) begin
                    fall_sel_q[i] <= 1'b0; // RULE_08
                    rise_sel_q[i] <= 1'b0;
                    ena_q[i] <= 1'b0;
                    flag_q[i] <= 1'b0;
                end else begin
                    fall_sel_q[i] <= fall_sel_d[i];
                    rise_sel_q[i] <= rise_sel_d[i];
                    ena_q[i] <= ena_d[i];
                    flag_q[i] <= flag_d[i]; // RULE_05
                end
            end

            // capture strobe toward the timer, one cycle per edge
            always @(posedge clock or negedge rst_b) begin
                if (!rst_b) begin
                    trig_q[i] <= 1'b0;
                end else begin
                    trig_q[i] <= hit[i]; // RULE_01
                end
            end

            // request follows flag and enable; a flag left pending with
            // the enable off fires as soon as the enable is written
            always @(posedge clock or negedge rst_b) begin
                if (!rst_b) begin
                    irq_q[i] <= 1'b0;
                end else begin
                    irq_q[i] <= flag_d[i] & ena_d[i]; // RULE_07 RULE_12
                end
            end

            // read image nibble {enable, flag, rise, fall}
            assign ctl_vec[i*4 + `CEC_FLD_FALL] = fall_sel_q[i];
            assign ctl_vec[i*4 + `CEC_FLD_RISE] = rise_sel_q[i];
            assign ctl_vec[i*4 + `CEC_FLD_FLAG] = flag_q[i]; // RULE_05
            assign ctl_vec[i*4 + `CEC_FLD_ENA] = ena_q[i];
        end
    endgenerate

    // the handler clears flags by software, so the request simply
    // stands until then
    assign capture_trigger = trig_q;
    assign irq_request = irq_q; // RULE_06

    // one summary request for a single interrupt line upstream
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            irq_any_q <= 1'b0;
        end else begin
            irq_any_q <= |(flag_d & ena_d); // RULE_12
        end
    end
    assign irq_any = irq_any_q;

    // ------------------------------------------------------------------
    // apb read data and error, sampled in the setup phase
    // ------------------------------------------------------------------

    reg [31:0] rdata_q;
    reg [31:0] rdata_d;
    reg err_q;

    // pick the addressed byte; bits above the byte read as zero
    always @* begin
        rdata_d = `CEC_RDATA_NONE;
        case (sel_reg)
            3'b001: begin
                rdata_d = {24'h00_0000, ctl_vec[7:0]}; // RULE_10
            end
            3'b010: begin
                rdata_d = {24'h00_0000, ctl_vec[15:8]}; // RULE_09
            end
            3'b100: begin
                rdata_d = {24'h00_0000, ctl_vec[23:16]}; // RULE_09
            end
            default: begin
                rdata_d = `CEC_RDATA_NONE;
            end
        endcase
    end

    // data is taken at the setup edge so the access phase shows it from
    // a flop; a flag set between setup and access shows next read
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rdata_q <= `CEC_RDATA_NONE;
            err_q <= 1'b0;
        end else if (setup_phase) begin
            rdata_q <= pwrite ? `CEC_RDATA_NONE : rdata_d;
            err_q <= ~mapped;
        end else if (!psel) begin
            rdata_q <= `CEC_RDATA_NONE;
            err_q <= 1'b0;
        end
    end

    // unmapped addresses answer with an error and zero data
    assign prdata = rdata_q;
    assign pslverr = err_q & access_phase;

endmodule // cec_capture_ctrl
